/* hdl/als_top.sv */
// terminal layer-2 address selection, scrambling seed and downlink filter
`timescale 1ns/1ps
module als_top
	import als_pkg::*;
(
	input  wire logic                     clk,              // system clock
	input  wire logic                     rst,              // async reset, high
	// network and cell identity
	input  wire logic [`ALS_CC_W-1:0]     countryCode,      // country code field
	input  wire logic [`ALS_NC_W-1:0]     networkCode,      // network code field
	input  wire logic [`ALS_COLOUR_W-1:0] colourCode,       // cell number
	output als_seed_t                     scrambleSeed,     // seed for scrambler
	// identities held
	input  als_ssi_t                      individualId,     // individual short id
	input  wire logic                     individualValid,  // individual id held
	input  als_ssi_t                      aliasId,          // alias short id
	input  wire logic                     aliasValid,       // alias id held
	input  als_ssi_t                      homeIndividualId, // home-allocated id
	input  wire logic                     homeIdValid,      // home id known
	input  als_ssi_t                      mgmtId,           // management id
	input  wire logic                     mgmtValid,        // management id held
	// group table write port
	input  wire logic                     groupWrEn,        // write one entry
	input  wire logic [`ALS_GIDX_W-1:0]   groupWrIdx,       // entry index
	input  als_ssi_t                      groupWrId,        // group id
	input  wire logic                     groupWrValid,     // entry valid bit
	// event label allocation
	input  wire logic                     labelAlloc,       // label assigned, pulse
	input  wire logic                     labelFree,        // label withdrawn, pulse
	input  wire logic [`ALS_LABEL_W-1:0]  labelValue,       // allocated label
	input  als_ssi_t                      labelOwner,       // id the label replaces
	// uplink address request
	input  wire logic                     ulReq,            // request, one cycle
	input  als_ul_kind_t                  ulKind,           // call situation
	input  wire logic                     ulReserved,       // reserved access
	input  wire logic                     ulPacket,         // packet channel
	input  als_ssi_t                      ulEchoId,         // id the base used
	input  als_ssi_t                      ulGroupId,        // group for presence
	output logic                          ulDone,           // answer, one cycle
	output als_ssi_t                      ulAddr,           // short id to send
	output logic [`ALS_LABEL_W-1:0]       ulLabel,          // label to send
	output als_id_type_t                  ulIdType,         // kind of address
	output logic                          ulUnexchFlag,     // unexchanged in pdu
	output logic                          ulError,          // no usable id
	// downlink pdu address
	input  wire logic                     dlReq,            // pdu header, one cycle
	input  wire logic                     dlAddressed,      // address field present
	input  wire logic                     dlIsLabel,        // field is event label
	input  als_ssi_t                      dlAddr,           // received short id
	input  wire logic [`ALS_LABEL_W-1:0]  dlLabel,          // received label
	input  wire logic                     dlMniPresent,     // network id present
	input  wire logic [`ALS_MNI_W-1:0]    dlMni,            // received network id
	output logic                          dlDone,           // answer, one cycle
	output logic                          dlAccept,         // pdu is for us
	output logic                          dlBroadcast,      // broadcast pdu
	output als_ssi_t                      dlDestId,         // destination id
	output als_reg_state_t                regState          // registration phase
);
	typedef struct packed {
		als_reg_state_t   phase;
		als_ssi_t         regUnexch;
		logic             labelValid;
		logic [`ALS_LABEL_W-1:0] label;
		als_ssi_t         labelOwner;
		als_group_state_t grp;
		logic             ulDone;
		als_ssi_t         ulAddr;
		logic [`ALS_LABEL_W-1:0] ulLabel;
		als_id_type_t     ulIdType;
		logic             ulUnexch;
		logic             ulError;
		logic             dlDone;
		logic             dlAccept;
		logic             dlBroadcast;
		als_ssi_t         dlDestId;
	} als_top_state_t;

	als_top_state_t stQ;
	als_top_state_t stD;

	als_id_if ids();

	logic ssiMatch;
	logic ssiBcast;
	logic mniOk;
	als_ssi_t primaryId;

	// scrambling seed is used unchanged for both directions
	als_seed_gen uSeed (
		.clk         (clk),
		.rst         (rst),
		.countryCode (countryCode),
		.networkCode (networkCode),
		.colourCode  (colourCode),
		.seed        (scrambleSeed)
	);

	// identities offered to the matcher; unexchanged id only while registering
	assign ids.individualId    = individualId;
	assign ids.individualValid = individualValid;
	assign ids.aliasId         = aliasId;
	assign ids.aliasValid      = aliasValid;
	assign ids.mgmtId          = mgmtId;
	assign ids.mgmtValid       = mgmtValid;
	assign ids.regUnexchId     = stQ.regUnexch;
	assign ids.regUnexchValid  = (stQ.phase == REG_PENDING);
	assign ids.groupId         = stQ.grp.groupId;
	assign ids.groupValid      = stQ.grp.groupValid;

	als_addr_match uMatch (
		.ids     (ids),
		.rxAddr  (dlAddr),
		.match   (ssiMatch),
		.isBcast (ssiBcast)
	);

	// own network, all-ones domain broadcast, or absent network field
	assign mniOk = !dlMniPresent || (dlMni == `ALS_BCAST_MNI)
		|| (dlMni == {countryCode, networkCode});

	// id the terminal currently answers to, alias first
	assign primaryId = aliasValid ? aliasId : individualId;

	// next state; the matcher is purely combinational so the answer is one cycle
	always_comb
	begin
		stD = stQ;
		stD.ulDone = 1'b0;
		stD.dlDone = 1'b0;

		// group table updates
		if (groupWrEn)
		begin
			stD.grp.groupId[groupWrIdx] = groupWrId;
			stD.grp.groupValid[groupWrIdx] = groupWrValid;
		end

		// 14-bit call references of traffic channels are held above this block
		// event label bookkeeping; a new allocation wins over a withdrawal
		if (labelFree)
			stD.labelValid = 1'b0;
		if (labelAlloc)
		begin
			stD.labelValid = 1'b1;
			stD.label = labelValue;
			stD.labelOwner = labelOwner;
		end

		// a held alias ends the unexchanged phase
		case (stQ.phase)
			REG_IDLE:
				stD.phase = REG_IDLE;
			REG_PENDING:
				if (aliasValid)
					stD.phase = REG_DONE;
			REG_DONE:
				if (!aliasValid && !individualValid)
					stD.phase = REG_IDLE;
			default:
				stD.phase = REG_IDLE;
		endcase

		// uplink address selection
		if (ulReq)
		begin
			stD.ulDone = 1'b1;
			stD.ulError = 1'b0;
			stD.ulUnexch = 1'b0;
			stD.ulLabel = `ALS_RST_LABEL;
			case (ulKind)
				UL_ORIGINATED, UL_GROUP_REPLY:
				begin
					if (aliasValid)
					begin
						stD.ulAddr = aliasId;
						stD.ulIdType = ID_ALIAS;
					end
					else if (individualValid)
					begin
						stD.ulAddr = individualId;
						stD.ulIdType = ID_INDIVIDUAL;
					end
					else if (homeIdValid)
					begin
						stD.ulAddr = homeIndividualId;
						stD.ulIdType = ID_UNEXCHANGED;
						stD.ulUnexch = 1'b1;
						stD.regUnexch = homeIndividualId;
						if (stQ.phase != REG_PENDING)
							stD.phase = REG_PENDING;
					end
					else
					begin
						stD.ulAddr = `ALS_RST_SSI;
						stD.ulIdType = ID_NONE;
						stD.ulError = 1'b1;
					end
				end
				UL_INDIV_REPLY:
				begin
					stD.ulAddr = ulEchoId;
					stD.ulIdType = (aliasValid && ulEchoId == aliasId) ? ID_ALIAS
						: ID_INDIVIDUAL;
				end
				UL_MGMT_REPLY:
				begin
					stD.ulAddr = mgmtId;
					stD.ulIdType = mgmtValid ? ID_MANAGEMENT : ID_NONE;
					stD.ulError = !mgmtValid;
				end
				UL_GROUP_PRES:
				begin
					stD.ulAddr = ulGroupId;
					stD.ulIdType = ID_GROUP;
				end
				default:
				begin
					stD.ulAddr = `ALS_RST_SSI;
					stD.ulIdType = ID_NONE;
					stD.ulError = 1'b1;
				end
			endcase
			// label replaces the id on reserved control access only
			if (ulReserved && !ulPacket && stQ.labelValid && !stD.ulError
				&& ulKind != UL_GROUP_PRES)
			begin
				stD.ulIdType = ID_EVENT_LABEL;
				stD.ulLabel = stQ.label;
			end
		end

		// downlink filter; a wrong scrambling label never reaches here
		if (dlReq)
		begin
			stD.dlDone = 1'b1;
			stD.dlBroadcast = 1'b0;
			stD.dlAccept = 1'b0;
			stD.dlDestId = primaryId;
			if (!dlAddressed)
			begin
				stD.dlAccept = 1'b1;
				stD.dlBroadcast = 1'b1;
			end
			else if (dlIsLabel)
			begin
				// translate the label back to the id it stands
				stD.dlAccept = stQ.labelValid && (dlLabel == stQ.label);
				stD.dlDestId = stQ.labelOwner;
			end
			else
			begin
				// id kind is not signalled, so every held id is tried
				stD.dlAccept = ssiMatch && mniOk;
				stD.dlBroadcast = ssiBcast;
				stD.dlDestId = dlAddr;
			end
		end
	end

	// single state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stQ.phase <= REG_IDLE;
			stQ.regUnexch <= `ALS_RST_SSI;
			stQ.labelValid <= 1'b0;
			stQ.label <= `ALS_RST_LABEL;
			stQ.labelOwner <= `ALS_RST_SSI;
			stQ.grp <= '0;
			stQ.ulDone <= 1'b0;
			stQ.ulAddr <= `ALS_RST_SSI;
			stQ.ulLabel <= `ALS_RST_LABEL;
			stQ.ulIdType <= ID_NONE;
			stQ.ulUnexch <= 1'b0;
			stQ.ulError <= 1'b0;
			stQ.dlDone <= 1'b0;
			stQ.dlAccept <= 1'b0;
			stQ.dlBroadcast <= 1'b0;
			stQ.dlDestId <= `ALS_RST_SSI;
		end
		else
			stQ <= stD;
	end

	// outputs straight from the state register
	assign ulDone       = stQ.ulDone;
	assign ulAddr       = stQ.ulAddr;
	assign ulLabel      = stQ.ulLabel;
	assign ulIdType     = stQ.ulIdType;
	assign ulUnexchFlag = stQ.ulUnexch;
	assign ulError      = stQ.ulError;
	assign dlDone       = stQ.dlDone;
	assign dlAccept     = stQ.dlAccept;
	assign dlBroadcast  = stQ.dlBroadcast;
	assign dlDestId     = stQ.dlDestId;
	assign regState     = stQ.phase;
endmodule

/* hdl/als_regs.svh */
// constants for the air-link address and label selection block
// Summary of operation
// - scrambling label joins network identity with the cell colour code
// - uplink is scrambled; unreserved uplink carries individual, alias, unexchanged, management or group id
// - call reference for circuit traffic channels is 14 bits
// - short identities are 24 bits and serve layer 2 and layer 3
// - event label is a 10-bit channel-local stand-in for a short id
// - seed uses colour code, country and network codes only, always
// - wrong label simply shows as a decode failure, no separate check
// - originated calls and group replies: alias, else individual, else unexchanged
// - reply to individual call with the same id the base used
// - reply to management call with the management id
// - group id goes uplink only in group presence indication
// - unexchanged id is a copy of a home-allocated individual id
// - reserved access uses the allocated event label instead of the id
// - packet channel pdus carry a short id or an event label
// - uplink packet pdus use short id only and flag its type
// - accept any validly held id, individual too when alias is held
// - unaddressed broadcast pdus count as addressed to every terminal
// - all-ones short id is a broadcast group every terminal accepts
// - all-ones network plus all-ones id is domain-wide broadcast
// - accept registration unexchanged id and the management id
// - network identity is 10-bit country code then 14-bit network code
// - deliver destination short id, translating event labels back
`ifndef ALS_REGS_SVH
`define ALS_REGS_SVH
`define ALS_SSI_W        24
`define ALS_LABEL_W      10
`define ALS_CALLREF_W    14
`define ALS_CC_W         10
`define ALS_NC_W         14
`define ALS_COLOUR_W     6
`define ALS_MNI_W        24
`define ALS_SEED_W       30
`define ALS_GROUPS       4
`define ALS_GIDX_W       2
`define ALS_BCAST_SSI    24'hffffff
`define ALS_BCAST_MNI    24'hffffff
`define ALS_RST_SSI      24'h000000
`define ALS_RST_LABEL    10'h000
`define ALS_RST_SEED     30'h00000000
`endif

/* hdl/als_pkg.sv */
// types shared by the address and label selection modules
`include "als_regs.svh"
package als_pkg;
	// uplink call situation that decides which id is sent
	typedef enum logic [2:0] {
		UL_ORIGINATED   = 3'h0,
		UL_GROUP_REPLY  = 3'h1,
		UL_INDIV_REPLY  = 3'h2,
		UL_MGMT_REPLY   = 3'h3,
		UL_GROUP_PRES   = 3'h4
	} als_ul_kind_t;
	// kind of address placed in an uplink pdu
	typedef enum logic [2:0] {
		ID_NONE        = 3'h0,
		ID_INDIVIDUAL  = 3'h1,
		ID_ALIAS       = 3'h2,
		ID_UNEXCHANGED = 3'h3,
		ID_MANAGEMENT  = 3'h4,
		ID_GROUP       = 3'h5,
		ID_EVENT_LABEL = 3'h6
	} als_id_type_t;
	// registration progress with the unexchanged id
	typedef enum logic [2:0] {
		REG_IDLE    = 3'b001,
		REG_PENDING = 3'b010,
		REG_DONE    = 3'b100
	} als_reg_state_t;
	typedef logic [`ALS_SSI_W-1:0] als_ssi_t;
	typedef logic [`ALS_SEED_W-1:0] als_seed_t;
	typedef struct packed {
		als_seed_t seed;
	} als_seed_state_t;
	typedef struct packed {
		logic [`ALS_GROUPS-1:0] groupValid;
		als_ssi_t [`ALS_GROUPS-1:0] groupId;
	} als_group_state_t;
endpackage

/* hdl/als_id_if.sv */
// identities held by the terminal, handed to the address matcher
`timescale 1ns/1ps
interface als_id_if;
	import als_pkg::*;
	als_ssi_t               individualId;
	logic                   individualValid;
	als_ssi_t               aliasId;
	logic                   aliasValid;
	als_ssi_t               mgmtId;
	logic                   mgmtValid;
	als_ssi_t               regUnexchId;
	logic                   regUnexchValid;
	als_ssi_t [`ALS_GROUPS-1:0] groupId;
	logic [`ALS_GROUPS-1:0] groupValid;
	modport src (output individualId, individualValid, aliasId, aliasValid, mgmtId,
		mgmtValid, regUnexchId, regUnexchValid, groupId, groupValid);
	modport mat (input individualId, individualValid, aliasId, aliasValid, mgmtId,
		mgmtValid, regUnexchId, regUnexchValid, groupId, groupValid);
endinterface

/* hdl/als_seed_gen.sv */
// registered scrambling seed from colour code and network identity
`timescale 1ns/1ps
module als_seed_gen
	import als_pkg::*;
(
	input  wire logic                     clk,          // system clock
	input  wire logic                     rst,          // async reset, high
	input  wire logic [`ALS_CC_W-1:0]     countryCode,  // country code field
	input  wire logic [`ALS_NC_W-1:0]     networkCode,  // network code field
	input  wire logic [`ALS_COLOUR_W-1:0] colourCode,   // cell number
	output als_seed_t                     seed          // scrambling seed
);
	als_seed_state_t stQ;
	als_seed_state_t stD;

	// country code, network code and colour code enter; no other identity bits
	always_comb
	begin
		stD = stQ;
		stD.seed = {countryCode, networkCode, colourCode};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stQ <= '{seed: `ALS_RST_SEED};
		else
			stQ <= stD;
	end

	assign seed = stQ.seed;
endmodule

/* hdl/als_addr_match.sv */
// compares a received short id with every identity the terminal holds
`timescale 1ns/1ps
module als_addr_match
	import als_pkg::*;
(
	als_id_if.mat       ids,       // held identities
	input  als_ssi_t    rxAddr,    // received address field
	output logic        match,     // any comparison succeeded
	output logic        isBcast    // address is the all-ones group
);
	// one held id compared in full, gated by its valid bit
	function automatic logic idHit(input als_ssi_t a, input als_ssi_t b, input logic v);
		idHit = v && (a == b);
	endfunction

	logic groupHit;

	// group table scan; a loop keeps the table depth a single constant
	always_comb
	begin
		groupHit = 1'b0;
		for (int i = 0; i < `ALS_GROUPS; i++)
			groupHit = groupHit | idHit(rxAddr, ids.groupId[i], ids.groupValid[i]);
	end

	assign isBcast = (rxAddr == `ALS_BCAST_SSI);
	// individual checked even when an alias is held
	assign match = isBcast | groupHit
		| idHit(rxAddr, ids.individualId, ids.individualValid)
		| idHit(rxAddr, ids.aliasId, ids.aliasValid)
		| idHit(rxAddr, ids.mgmtId, ids.mgmtValid)
		| idHit(rxAddr, ids.regUnexchId, ids.regUnexchValid);
endmodule

/* tb/als_top_asserts.sv */
// concurrent checks on the ports of the address and label selection top
`timescale 1ns/1ps
module als_top_chk
	import als_pkg::*;
(
	input wire logic       clk,              // clock
	input wire logic       rst,              // async reset
	input wire logic [9:0] countryCode,      // country code
	input wire logic [13:0] networkCode,     // network code
	input wire logic [5:0] colourCode,       // cell number
	input als_seed_t       scrambleSeed,     // seed out
	input als_ssi_t        individualId,     // individual id
	input wire logic       individualValid,  // individual held
	input als_ssi_t        aliasId,          // alias id
	input wire logic       aliasValid,       // alias held
	input als_ssi_t        homeIndividualId, // home id
	input wire logic       homeIdValid,      // home id known
	input wire logic       ulReq,            // uplink request
	input als_ul_kind_t    ulKind,           // call situation
	input wire logic       ulReserved,       // reserved access
	input als_ssi_t        ulEchoId,         // id used by base
	input wire logic       ulDone,           // uplink answer
	input als_ssi_t        ulAddr,           // id sent
	input als_id_type_t    ulIdType,         // kind sent
	input wire logic       ulUnexchFlag,     // unexchanged flag
	input wire logic       dlReq,            // downlink header
	input wire logic       dlAddressed,      // address present
	input wire logic       dlIsLabel,        // label field
	input als_ssi_t        dlAddr,           // address field
	input wire logic       dlMniPresent,     // network id present
	input wire logic       dlDone,           // downlink answer
	input wire logic       dlAccept,         // pdu for us
	input wire logic       dlBroadcast,      // broadcast pdu
	input als_ssi_t        dlDestId          // destination id
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// cell identity as the seed should carry it
	logic [29:0] cellSeed;
	assign cellSeed = {countryCode, networkCode, colourCode};
	// an unreserved call that follows the preference order
	sequence s_origCall;
		ulReq && !ulReserved && (ulKind == UL_ORIGINATED || ulKind == UL_GROUP_REPLY);
	endsequence
	sequence s_allOnes;
		dlReq && dlAddressed && !dlIsLabel && dlAddr == 24'hffffff && !dlMniPresent;
	endsequence
	AST_SEED: assert property (!$past(rst) |-> scrambleSeed == $past(cellSeed))
		else $error("seed does not follow cell identity");
	AST_UL_DONE: assert property (ulReq |=> ulDone)
		else $error("uplink answer missing");
	AST_UL_ALIAS: assert property (s_origCall ##0 aliasValid
		|=> ulIdType == ID_ALIAS && ulAddr == $past(aliasId))
		else $error("alias not preferred");
	AST_UL_UNEXCH: assert property (s_origCall ##0 (!aliasValid && !individualValid && homeIdValid)
		|=> ulIdType == ID_UNEXCHANGED && ulUnexchFlag && ulAddr == $past(homeIndividualId))
		else $error("unexchanged id not a home copy");
	AST_UL_ECHO: assert property (ulReq && ulKind == UL_INDIV_REPLY |=> ulAddr == $past(ulEchoId))
		else $error("reply id differs from id used by base");
	AST_UL_GROUP: assert property (ulDone && ulIdType == ID_GROUP
		|-> $past(ulReq) && $past(ulKind) == UL_GROUP_PRES)
		else $error("group id outside presence indication");
	AST_DL_UNADDR: assert property (dlReq && !dlAddressed |=> dlDone && dlAccept && dlBroadcast)
		else $error("unaddressed pdu not taken");
	AST_DL_BCAST: assert property (s_allOnes |=> dlAccept && dlBroadcast && dlDestId == 24'hffffff)
		else $error("all-ones group not accepted");
	AST_DL_INDIV: assert property (dlReq && dlAddressed && !dlIsLabel && !dlMniPresent
		&& individualValid && dlAddr == individualId |=> dlAccept)
		else $error("held individual id refused");
endmodule

bind als_top als_top_chk u_als_top_chk (
	.clk, .rst, .countryCode, .networkCode, .colourCode, .scrambleSeed,
	.individualId, .individualValid, .aliasId, .aliasValid, .homeIndividualId, .homeIdValid,
	.ulReq, .ulKind, .ulReserved, .ulEchoId, .ulDone, .ulAddr, .ulIdType, .ulUnexchFlag,
	.dlReq, .dlAddressed, .dlIsLabel, .dlAddr, .dlMniPresent, .dlDone, .dlAccept,
	.dlBroadcast, .dlDestId
);

/* tb/als_bs_model.sv */
// base station model issuing downlink pdu headers to the terminal
`timescale 1ns/1ps
module als_bs_model
	import als_pkg::*;
(
	input  wire logic  clk,          // clock
	output logic       dlReq,        // header strobe
	output logic       dlAddressed,  // address present
	output logic       dlIsLabel,    // label in place of id
	output als_ssi_t   dlAddr,       // address field
	output logic [9:0] dlLabel,      // label field
	output logic       dlMniPresent, // network id present
	output logic [23:0] dlMni        // network id
);
	// quiet air at time zero
	initial
	begin
		{dlReq, dlAddressed, dlIsLabel, dlMniPresent} = 4'h0;
		{dlAddr, dlLabel, dlMni} = 58'h0;
	end
	// fields stand for a pdu already descrambled with the cell seed
	// one header held over the taking edge; fields then change so stale values never match
	task automatic send(input logic ad, lb, input als_ssi_t a, input logic [9:0] l,
		input logic mp, input logic [23:0] m);
		@(posedge clk);
		dlReq <= 1'b1;
		dlAddressed <= ad;
		dlIsLabel <= lb;
		dlAddr <= a;
		dlLabel <= l;
		dlMniPresent <= mp;
		dlMni <= m;
		@(posedge clk);
		dlReq <= 1'b0;
		dlAddr <= ~a;
		dlLabel <= ~l;
		dlMni <= ~m;
		#1;
	endtask
endmodule

/* tb/als_top_test.sv */
// self-checking bench for the address and label selection top
`timescale 1ns/1ps
module als_top_test;
	import als_pkg::*;
	logic           clk, rst, individualValid, aliasValid, homeIdValid, mgmtValid;
	logic           groupWrEn, groupWrValid, labelAlloc, labelFree, ulReq, ulReserved, ulPacket;
	logic [9:0]     countryCode, labelValue, ulLabel, dlLabel;
	logic [13:0]    networkCode;
	logic [5:0]     colourCode;
	logic [1:0]     groupWrIdx;
	logic [23:0]    dlMni;
	als_ssi_t       individualId, aliasId, homeIndividualId, mgmtId, groupWrId, labelOwner;
	als_ssi_t       ulEchoId, ulGroupId, ulAddr, dlAddr, dlDestId;
	als_ul_kind_t   ulKind;
	als_id_type_t   ulIdType;
	als_seed_t      scrambleSeed;
	als_reg_state_t regState;
	logic           ulDone, ulUnexchFlag, ulError, dlReq, dlAddressed, dlIsLabel, dlMniPresent;
	logic           dlDone, dlAccept, dlBroadcast;
	int             n_fail, checks;

	als_top u_als_top (.clk, .rst, .countryCode, .networkCode, .colourCode, .scrambleSeed,
		.individualId, .individualValid, .aliasId, .aliasValid, .homeIndividualId,
		.homeIdValid, .mgmtId, .mgmtValid, .groupWrEn, .groupWrIdx, .groupWrId, .groupWrValid,
		.labelAlloc, .labelFree, .labelValue, .labelOwner, .ulReq, .ulKind, .ulReserved,
		.ulPacket, .ulEchoId, .ulGroupId, .ulDone, .ulAddr, .ulLabel, .ulIdType, .ulUnexchFlag,
		.ulError, .dlReq, .dlAddressed, .dlIsLabel, .dlAddr, .dlLabel, .dlMniPresent, .dlMni,
		.dlDone, .dlAccept, .dlBroadcast, .dlDestId, .regState);
	als_bs_model u_als_bs_model (.clk, .dlReq, .dlAddressed, .dlIsLabel, .dlAddr, .dlLabel,
		.dlMniPresent, .dlMni);

	// 125 MHz
	always #4 clk = ~clk;

	task automatic chk(input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one uplink request; the answer is registered at the taking edge and checked 1 ns later
	task automatic ul(input als_ul_kind_t k, input logic r, p, input als_ssi_t ea,
		input als_id_type_t et);
		@(posedge clk);
		ulReq <= 1'b1;
		ulKind <= k;
		ulReserved <= r;
		ulPacket <= p;
		@(posedge clk);
		ulReq <= 1'b0;
		#1;
		chk(ulDone, 1'b1);
		chk(ulAddr, ea);
		chk(ulIdType, et);
	endtask

	task automatic dlc(input logic ea, eb, input als_ssi_t ed);
		chk(dlDone, 1'b1);
		chk({dlAccept, dlBroadcast}, {ea, eb});
		chk(dlDestId, ed);
	endtask

	task automatic t_seed();
		repeat (2) @(posedge clk);
		#1;
		chk(scrambleSeed, {10'h2a5, 14'h1b3c, 6'h15});
		@(posedge clk);
		networkCode <= 14'h0001;
		colourCode <= 6'h2a;
		@(posedge clk);
		#1;
		chk(scrambleSeed, {10'h2a5, 14'h0001, 6'h2a});
	endtask

	// preference order, then home copy, registration id, and no usable id
	task automatic t_ul_select();
		@(posedge clk);
		{aliasValid, individualValid} <= 2'b11;
		ul(UL_ORIGINATED, 1'b0, 1'b0, 24'h00abcd, ID_ALIAS);
		ul(UL_GROUP_REPLY, 1'b0, 1'b0, 24'h00abcd, ID_ALIAS);
		@(posedge clk);
		aliasValid <= 1'b0;
		ul(UL_ORIGINATED, 1'b0, 1'b0, 24'h123456, ID_INDIVIDUAL);
		@(posedge clk);
		{individualValid, homeIdValid} <= 2'b01;
		ul(UL_GROUP_REPLY, 1'b0, 1'b0, 24'h777001, ID_UNEXCHANGED);
		chk(ulUnexchFlag, 1'b1);
		u_als_bs_model.send(1'b1, 1'b0, 24'h777001, 10'h0, 1'b0, 24'h0);
		dlc(1'b1, 1'b0, 24'h777001);
		chk(regState, REG_PENDING);
		@(posedge clk);
		homeIdValid <= 1'b0;
		ul(UL_ORIGINATED, 1'b0, 1'b0, 24'h000000, ID_NONE);
		chk(ulError, 1'b1);
		@(posedge clk);
		{aliasValid, individualValid} <= 2'b11;
		repeat (2) @(posedge clk);
		#1;
		chk(regState, REG_DONE);
	endtask

	task automatic t_ul_replies();
		ul(UL_INDIV_REPLY, 1'b0, 1'b0, 24'h123456, ID_INDIVIDUAL);
		@(posedge clk);
		ulEchoId <= 24'h00abcd;
		ul(UL_INDIV_REPLY, 1'b0, 1'b0, 24'h00abcd, ID_ALIAS);
		ul(UL_MGMT_REPLY, 1'b0, 1'b0, 24'h5a5a5a, ID_MANAGEMENT);
		ul(UL_GROUP_PRES, 1'b0, 1'b0, 24'h0c0c0c, ID_GROUP);
	endtask

	// label replaces the id on reserved control access only; received labels map back to the owner
	task automatic t_label();
		@(posedge clk);
		labelAlloc <= 1'b1;
		@(posedge clk);
		labelAlloc <= 1'b0;
		ul(UL_ORIGINATED, 1'b1, 1'b0, 24'h00abcd, ID_EVENT_LABEL);
		chk(ulLabel, 10'h3c5);
		ul(UL_ORIGINATED, 1'b1, 1'b1, 24'h00abcd, ID_ALIAS);
		u_als_bs_model.send(1'b1, 1'b1, 24'h0, 10'h3c5, 1'b0, 24'h0);
		dlc(1'b1, 1'b0, 24'h123456);
		u_als_bs_model.send(1'b1, 1'b1, 24'h0, 10'h3c4, 1'b0, 24'h0);
		chk(dlAccept, 1'b0);
		@(posedge clk);
		labelFree <= 1'b1;
		@(posedge clk);
		labelFree <= 1'b0;
		ul(UL_ORIGINATED, 1'b1, 1'b0, 24'h00abcd, ID_ALIAS);
	endtask

	task automatic t_dl();
		u_als_bs_model.send(1'b0, 1'b0, 24'h0, 10'h0, 1'b0, 24'h0);
		dlc(1'b1, 1'b1, 24'h00abcd);
		u_als_bs_model.send(1'b1, 1'b0, 24'hffffff, 10'h0, 1'b1, 24'hffffff);
		dlc(1'b1, 1'b1, 24'hffffff);
		u_als_bs_model.send(1'b1, 1'b0, 24'hffffff, 10'h0, 1'b0, 24'h0);
		dlc(1'b1, 1'b1, 24'hffffff);
		u_als_bs_model.send(1'b1, 1'b0, 24'h123456, 10'h0, 1'b1, {10'h2a5, 14'h0001});
		dlc(1'b1, 1'b0, 24'h123456);
		u_als_bs_model.send(1'b1, 1'b0, 24'h123456, 10'h0, 1'b0, 24'h0);
		dlc(1'b1, 1'b0, 24'h123456);
		u_als_bs_model.send(1'b1, 1'b0, 24'h123456, 10'h0, 1'b1, 24'h000001);
		chk(dlAccept, 1'b0);
		u_als_bs_model.send(1'b1, 1'b0, 24'h5a5a5a, 10'h0, 1'b0, 24'h0);
		dlc(1'b1, 1'b0, 24'h5a5a5a);
		u_als_bs_model.send(1'b1, 1'b0, 24'h0c0c0c, 10'h0, 1'b0, 24'h0);
		chk(dlAccept, 1'b0);
		@(posedge clk);
		{groupWrEn, groupWrValid, groupWrIdx} <= 4'hf;
		@(posedge clk);
		groupWrEn <= 1'b0;
		u_als_bs_model.send(1'b1, 1'b0, 24'h0c0c0c, 10'h0, 1'b0, 24'h0);
		dlc(1'b1, 1'b0, 24'h0c0c0c);
	endtask

	initial
	begin
		{clk, rst, n_fail, checks} = {1'b0, 1'b1, 32'h0, 32'h0};
		{individualValid, aliasValid, homeIdValid, mgmtValid} = 4'h1;
		{groupWrEn, groupWrValid, groupWrIdx, labelAlloc, labelFree} = 6'h0;
		{ulReq, ulReserved, ulPacket, ulKind} = {3'h0, UL_ORIGINATED};
		{countryCode, networkCode, colourCode} = {10'h2a5, 14'h1b3c, 6'h15};
		{individualId, aliasId, homeIndividualId} = {24'h123456, 24'h00abcd, 24'h777001};
		{mgmtId, groupWrId, ulGroupId} = {24'h5a5a5a, 24'h0c0c0c, 24'h0c0c0c};
		{labelValue, labelOwner, ulEchoId} = {10'h3c5, 24'h123456, 24'h123456};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_seed();
		t_ul_select();
		t_ul_replies();
		t_label();
		t_dl();
		report_and_stop();
	end

	// a hang ends the run as a failure
	initial
	begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule
